// File: design/exc_pkg.sv
// Constants, types and state encodings shared by the exception sequencer.
// Summary of operation
// - Reset input starts top priority, unrecoverable sequence.
// - Reset sets supervisor, clears master and trace.
// - Reset loads interrupt mask with seven.
// - Reset clears vector base register.
// - Reset clears instruction and data cache enables.
// - Reset clears translation enable, keeps page size.
// - Reset clears all four transparent translation enables.
// - Interrupt acknowledge cycle yields reset vector number.
// - Read vectors 0,1: stack pointer, program counter.
// - Prefetch four longwords at new program counter.
// - No cache flush, no context save.
// - Fault during reset: halt, status code five.
// - Reset instruction pulses reset output only.
// - Groups 0-2: reset, data error, pre-instruction.
// - Groups 3-8 in fixed order down to interrupt.
// - Only highest pending exception is processed.
// - Pending interrupt preempts entry to first handler.
// - Access error frame records trace or float pending.
// - Error, trace, float together: record float only.
// - Trace with group 3 or post not reported.
// - Pre-instruction exception taken before instruction executes.
package exc_pkg;

  localparam logic [31:0] WB_ADR_STATUS   = 32'h0000_0000;
  localparam logic [31:0] WB_ADR_SR       = 32'h0000_0004;
  localparam logic [31:0] WB_ADR_VBR      = 32'h0000_0008;
  localparam logic [31:0] WB_ADR_CACHE_CONTROL_REGISTER     = 32'h0000_000c;
  localparam logic [31:0] WB_ADR_TC       = 32'h0000_0010;
  localparam logic [31:0] WB_ADR_TT0      = 32'h0000_0014;
  localparam logic [31:0] WB_ADR_ISP      = 32'h0000_0024;
  localparam logic [31:0] WB_ADR_PC       = 32'h0000_0028;
  localparam logic [31:0] WB_ADR_PEND     = 32'h0000_002c;
  localparam logic [31:0] WB_ADR_RESULT   = 32'h0000_0030;
  localparam logic [31:0] WB_ADR_CMD      = 32'h0000_0034;

  localparam int SR_T1_BIT  = 15;
  localparam int SR_T0_BIT  = 14;
  localparam int SR_S_BIT   = 13;
  localparam int SR_M_BIT   = 12;
  localparam int SR_IPM_LSB = 8;
  localparam logic [2:0] IPM_RESET_LEVEL = 3'h7;

  localparam int CACHE_CONTROL_REGISTER_DE_BIT = 31;
  localparam int CACHE_CONTROL_REGISTER_IE_BIT = 15;
  localparam int TC_E_BIT    = 15;
  localparam int TT_E_BIT    = 15;
  localparam int NUM_TT      = 4;

  localparam logic [31:0] VBR_RESET      = 32'h0000_0000;
  localparam logic [31:0] RESET_VEC_ADDR = 32'h0000_0000;
  localparam logic [31:0] LONG_BYTES     = 32'h0000_0004;
  localparam logic [2:0]  PREFETCH_LONGS = 3'h4;

  localparam logic [3:0] PST_NORMAL     = 4'h0;
  localparam logic [3:0] PST_DOUBLE_BUS = 4'h5;
  localparam logic [2:0] TM_RESET_ACK   = 3'h0;
  localparam logic [2:0] FSIZE_RESET    = 3'h7;
  localparam logic [3:0] FORMAT_ACCESS  = 4'h7;

  localparam int RESET_OUTPUT_PIN_NS     = 100;
  localparam int CLK_MHZ     = 200;
  localparam int RESET_OUTPUT_PIN_CYCLES = (RESET_OUTPUT_PIN_NS * CLK_MHZ + 999) / 1000;

  // Exception request bits, one per source.
  localparam int EX_RESET   = 0;
  localparam int EX_DACC    = 1;
  localparam int EX_FPPRE   = 2;
  localparam int EX_TRAP    = 3;
  localparam int EX_ILLEGAL = 4;
  localparam int EX_FPPOST  = 5;
  localparam int EX_ADDR    = 6;
  localparam int EX_TRACE   = 7;
  localparam int EX_IACC    = 8;
  localparam int EX_INTR    = 9;
  localparam int EX_COUNT   = 10;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_STATUS   = 4'b0001,
    ST_CLEAR    = 4'b0010,
    ST_IACK     = 4'b0011,
    ST_READ_SP  = 4'b0100,
    ST_READ_PC  = 4'b0101,
    ST_PREFETCH = 4'b0110,
    ST_RUN      = 4'b0111,
    ST_HALT     = 4'b1000
  } seq_state_type;

  typedef struct packed {
    logic [31:0] adr;
    logic        we;
    logic        cyc;
    logic        stb;
    logic        iack;
    logic [2:0]  tm;
  } mem_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } mem_rsp_type;

  typedef struct packed {
    logic [3:0] group;
    logic       valid;
    logic       preempt_intr;
    logic       trace_hidden;
    logic       frame_trace;
    logic       frame_fp;
  } exc_result_type;

endpackage : exc_pkg

// File: design/reset_exception_priority_unit.sv
// Reset exception sequencer and simultaneous exception arbiter.
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
module reset_exception_priority_unit
  import exc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              reset_input_pin_n_i,
  input  wire logic [EX_COUNT-1:0] exc_pending_i,
  input  wire logic              mem_ack_i,
  input  wire logic              mem_err_i,
  input  wire logic [31:0]       mem_dat_i,
  output logic [31:0]            mem_adr_o,
  output logic                   mem_cyc_o,
  output logic                   mem_iack_o,
  output logic [2:0]             mem_tm_o,
  output logic                   mem_super_o,
  output logic [3:0]             processor_status_code_o,
  output logic                   reset_output_pin_n_o,
  output logic                   run_o,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchroniser: three stages, a change counts once two agree.

  logic [2:0] reset_input_pin_sync_q;
  logic       reset_input_pin_level_q;

  // Stage one feeds stage two only; the agreement test looks at two and three.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_input_pin_sync_q  <= 3'h7;
      reset_input_pin_level_q <= 1'b0;
    end else begin
      reset_input_pin_sync_q <= {reset_input_pin_sync_q[1:0], reset_input_pin_n_i};
      if (reset_input_pin_sync_q[1] == reset_input_pin_sync_q[2]) begin
        reset_input_pin_level_q <= ~reset_input_pin_sync_q[2];
      end
    end
  end

  logic reset_req;
  assign reset_req = reset_input_pin_level_q | rst_i;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  seq_state_type state_q;
  logic [2:0]    pf_cnt_q;
  logic [31:0]   sr_q;
  logic [31:0]   vbr_q;
  logic [31:0]   cache_control_register_q;
  logic [31:0]   tc_q;
  logic [31:0]   tt_q [NUM_TT];
  logic [31:0]   isp_q;
  logic [31:0]   pc_q;
  logic          wb_write;
  logic          bus_done;
  logic          bus_fault;

  assign wb_write  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign bus_done  = mem_cyc_o & mem_ack_i;
  assign bus_fault = mem_cyc_o & mem_err_i;

  // Main step order; any new reset request restarts at the first step.
  always_ff @(posedge clk_i) begin
    if (reset_req) begin
      state_q  <= ST_STATUS;
      pf_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_STATUS: begin
          state_q <= ST_CLEAR;
        end
        ST_CLEAR: begin
          state_q <= ST_IACK;
        end
        ST_IACK: begin
          if (bus_fault) begin
            state_q <= ST_HALT;
          end else if (bus_done) begin
            state_q <= ST_READ_SP;
          end
        end
        ST_READ_SP: begin
          if (bus_fault) begin
            state_q <= ST_HALT;
          end else if (bus_done) begin
            state_q <= ST_READ_PC;
          end
        end
        ST_READ_PC: begin
          if (bus_fault) begin
            state_q <= ST_HALT;
          end else if (bus_done) begin
            state_q <= ST_PREFETCH;
          end
        end
        ST_PREFETCH: begin
          if (bus_fault) begin
            state_q <= ST_HALT;
          end else if (bus_done) begin
            pf_cnt_q <= pf_cnt_q + 3'h1;
            if (pf_cnt_q == PREFETCH_LONGS - 3'h1) begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        ST_HALT: state_q <= ST_HALT; // Only a new reset leaves a double bus fault.
        default: state_q <= ST_STATUS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural control registers; once running, software may write all but the stack pointer and program counter.

  // Status word: privilege, trace and mask take their reset values first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_q <= 32'h0000_2700;
    end else if (state_q == ST_STATUS) begin
      sr_q[SR_S_BIT]  <= 1'b1;
      sr_q[SR_M_BIT]  <= 1'b0;
      sr_q[SR_T1_BIT] <= 1'b0;
      sr_q[SR_T0_BIT] <= 1'b0;
      sr_q[SR_IPM_LSB+:3] <= IPM_RESET_LEVEL;
    end else if (wb_write && wb_adr_i == WB_ADR_SR) begin
      sr_q <= {16'h0000, wb_dat_i[15:0]};
    end
  end

  // Vector base and cache enables; cache contents are never touched here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbr_q  <= VBR_RESET;
      cache_control_register_q <= 32'h0000_0000;
    end else if (state_q == ST_CLEAR) begin
      vbr_q <= VBR_RESET;
      cache_control_register_q[CACHE_CONTROL_REGISTER_DE_BIT] <= 1'b0;
      cache_control_register_q[CACHE_CONTROL_REGISTER_IE_BIT] <= 1'b0;
    end else if (wb_write && wb_adr_i == WB_ADR_VBR) begin
      vbr_q <= wb_dat_i;
    end else if (wb_write && wb_adr_i == WB_ADR_CACHE_CONTROL_REGISTER) begin
      cache_control_register_q <= wb_dat_i;
    end
  end

  // Translation control: only the enable falls, the page size survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_q <= 32'h0000_0000;
    end else if (state_q == ST_CLEAR) begin
      tc_q[TC_E_BIT] <= 1'b0;
    end else if (wb_write && wb_adr_i == WB_ADR_TC) begin
      tc_q <= wb_dat_i;
    end
  end

  // Each transparent translation register loses its enable.
  genvar g;
  generate
    for (g = 0; g < NUM_TT; g++) begin : g_tt
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tt_q[g] <= 32'h0000_0000;
        end else if (state_q == ST_CLEAR) begin
          tt_q[g][TT_E_BIT] <= 1'b0;
        end else if (wb_write && wb_adr_i == WB_ADR_TT0 + 32'(4 * g)) begin
          tt_q[g] <= wb_dat_i;
        end
      end
    end
  endgenerate

  // Stack pointer and program counter come from the two vector longwords.
  // No old context is stored anywhere during the sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isp_q <= 32'h0000_0000;
      pc_q  <= 32'h0000_0000;
    end else if (state_q == ST_READ_SP && bus_done) begin
      isp_q <= mem_dat_i;
    end else if (state_q == ST_READ_PC && bus_done) begin
      pc_q <= mem_dat_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory request, registered; one request in each of the acknowledge and two vector steps, four in the prefetch step, dropped after answer.

  always_ff @(posedge clk_i) begin
    if (reset_req) begin
      mem_cyc_o   <= 1'b0;
      mem_iack_o  <= 1'b0;
      mem_adr_o   <= 32'h0000_0000;
      mem_tm_o    <= 3'h0;
      mem_super_o <= 1'b1;
    end else if (mem_cyc_o) begin
      // The request stands until the far side answers, so slow memory is never cut short.
      if (bus_done || bus_fault) begin
        mem_cyc_o  <= 1'b0;
        mem_iack_o <= 1'b0;
      end
    end else begin
      mem_super_o <= 1'b1;
      case (state_q)
        ST_IACK: begin
          mem_cyc_o  <= 1'b1;
          mem_iack_o <= 1'b1;
          mem_tm_o   <= FSIZE_RESET;
          mem_adr_o  <= 32'h0000_0000;
        end
        ST_READ_SP: begin
          mem_cyc_o <= 1'b1;
          mem_tm_o  <= TM_RESET_ACK;
          mem_adr_o <= RESET_VEC_ADDR;
        end
        ST_READ_PC: begin
          mem_cyc_o <= 1'b1;
          mem_adr_o <= RESET_VEC_ADDR + LONG_BYTES;
        end
        ST_PREFETCH: begin
          mem_cyc_o <= 1'b1;
          mem_adr_o <= pc_q + {27'h0, pf_cnt_q, 2'h0};
        end
        default: mem_cyc_o <= 1'b0;
      endcase
    end
  end

  // Status code and run flag reflect halt and completion.
  always_ff @(posedge clk_i) begin
    if (reset_req) begin
      processor_status_code_o <= PST_NORMAL;
      run_o <= 1'b0;
    end else begin
      processor_status_code_o <= (state_q == ST_HALT) ? PST_DOUBLE_BUS : PST_NORMAL;
      run_o <= (state_q == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset output: the reset instruction pulses it without internal effect.

  localparam logic [7:0] RESET_OUTPUT_PIN_LEN = 8'(RESET_OUTPUT_PIN_CYCLES);
  logic [7:0] reset_output_pin_cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_output_pin_cnt_q           <= 8'h00;
      reset_output_pin_n_o <= 1'b1;
    end else begin
      if (wb_write && wb_adr_i == WB_ADR_CMD && wb_dat_i[0] && state_q == ST_RUN) begin
        reset_output_pin_cnt_q <= RESET_OUTPUT_PIN_LEN;
      end else if (reset_output_pin_cnt_q != 8'h00) begin
        reset_output_pin_cnt_q <= reset_output_pin_cnt_q - 8'h01;
      end
      reset_output_pin_n_o <= ~(reset_output_pin_cnt_q != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority arbiter over pending exceptions.

  exc_result_type arb_d;
  exc_result_type arb_q;

  // Fixed group order; a lone winner is taken, the rest regenerate later.
  always_comb begin
    arb_d = '0;
    arb_d.valid = 1'b1;
    if (exc_pending_i[EX_RESET]) begin
      arb_d.group = 4'h0;
    end else if (exc_pending_i[EX_DACC]) begin
      arb_d.group = 4'h1;
      arb_d.frame_fp = exc_pending_i[EX_FPPOST];
      arb_d.frame_trace = exc_pending_i[EX_TRACE] & ~exc_pending_i[EX_FPPOST];
    end else if (exc_pending_i[EX_FPPRE]) begin
      arb_d.group = 4'h2;
    end else if (exc_pending_i[EX_TRAP] || exc_pending_i[EX_ILLEGAL]) begin
      arb_d.group = 4'h3;
      arb_d.trace_hidden = exc_pending_i[EX_TRACE];
    end else if (exc_pending_i[EX_FPPOST]) begin
      arb_d.group = 4'h4;
      arb_d.trace_hidden = exc_pending_i[EX_TRACE];
    end else if (exc_pending_i[EX_ADDR]) begin
      arb_d.group = 4'h5;
    end else if (exc_pending_i[EX_TRACE]) begin
      arb_d.group = 4'h6;
    end else if (exc_pending_i[EX_IACC]) begin
      arb_d.group = 4'h7;
    end else if (exc_pending_i[EX_INTR]) begin
      arb_d.group = 4'h8;
    end else begin
      arb_d.valid = 1'b0;
    end
    arb_d.preempt_intr = arb_d.valid && arb_d.group != 4'h0 && arb_d.group != 4'h8
                         && exc_pending_i[EX_INTR];
  end

  // Result held for software; reset removes every other pending outcome.
  always_ff @(posedge clk_i) begin
    if (reset_req) begin
      arb_q <= '0;
    end else begin
      arb_q <= arb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: one-cycle answer, unmapped reads give zero.

  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      WB_ADR_STATUS: rd_d = {28'h0, state_q};
      WB_ADR_SR:     rd_d = sr_q;
      WB_ADR_VBR:    rd_d = vbr_q;
      WB_ADR_CACHE_CONTROL_REGISTER:   rd_d = cache_control_register_q;
      WB_ADR_TC:     rd_d = tc_q;
      WB_ADR_ISP:    rd_d = isp_q;
      WB_ADR_PC:     rd_d = pc_q;
      WB_ADR_PEND:   rd_d = {22'h0, exc_pending_i};
      WB_ADR_RESULT: rd_d = {23'h0, arb_q};
      default: begin
        for (int i = 0; i < NUM_TT; i++) begin
          if (wb_adr_i == WB_ADR_TT0 + 32'(4 * i)) begin
            rd_d = tt_q[i];
          end
        end
      end
    endcase
  end

  // Ack lasts one cycle and drops the cycle after it was given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_d;
    end
  end

endmodule : reset_exception_priority_unit

// File: bench/exc_checker_sva.sv
// Port checker for the reset sequencer, the reset output and the register bus answer.
`timescale 1ns/1ps
module exc_checker
  import exc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reset_input_pin_n_i,
  input wire logic        mem_ack_i,
  input wire logic        mem_err_i,
  input wire logic [31:0] mem_dat_i,
  input wire logic [31:0] mem_adr_o,
  input wire logic        mem_cyc_o,
  input wire logic        mem_iack_o,
  input wire logic        mem_super_o,
  input wire logic [3:0]  processor_status_code_o,
  input wire logic        reset_output_pin_n_o,
  input wire logic        run_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic [31:0] pc_q;
  logic [2:0]  pf_q;
  logic        in_pf_q;
  logic [5:0]  lo_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !reset_input_pin_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Follow the prefetch so each fetch address can be predicted from the loaded counter.
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_input_pin_n_i) begin
      in_pf_q <= 1'b0;
      pf_q    <= 3'h0;
    end else if (mem_ack_i && mem_cyc_o && !mem_iack_o && mem_adr_o == 32'h4 && !in_pf_q) begin
      in_pf_q <= 1'b1;
      pc_q    <= mem_dat_i;
    end else if (in_pf_q && mem_cyc_o && mem_ack_i) begin
      pf_q <= pf_q + 3'h1;
    end
  end

  // Count cycles of the reset output pulse; a long count needs no deep repetition.
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_output_pin_n_o) begin
      lo_q <= 6'h0;
    end else begin
      lo_q <= lo_q + 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_quiet;
    !mem_cyc_o && !run_o && reset_output_pin_n_o && processor_status_code_o == 4'h0;
  endsequence
  sequence s_iack;
    mem_cyc_o && mem_iack_o;
  endsequence
  sequence s_done;
    mem_cyc_o && (mem_ack_i || mem_err_i);
  endsequence

  a_reset_start: assert property ($fell(rst_i) |-> s_quiet ##[1:4] s_iack)
    else $error("sequence did not open with an acknowledge cycle");
  a_hold_req: assert property (mem_cyc_o && !mem_ack_i && !mem_err_i |=>
    mem_cyc_o && $stable(mem_adr_o) && $stable(mem_iack_o))
    else $error("memory request changed before its answer");
  a_cyc_release: assert property (s_done |=> !mem_cyc_o)
    else $error("memory request held after its answer");
  a_vec_after_iack: assert property (s_iack ##0 mem_ack_i |=> ##[1:3]
    (mem_cyc_o && !mem_iack_o && mem_adr_o == RESET_VEC_ADDR))
    else $error("first vector read missing after acknowledge");
  a_pc_after_sp: assert property (mem_cyc_o && mem_ack_i && !mem_iack_o && !in_pf_q &&
    mem_adr_o == 32'h0 |=> ##[1:3] (mem_cyc_o && mem_adr_o == 32'h4))
    else $error("second vector read missing");
  a_prefetch_addr: assert property (in_pf_q && pf_q < 3'h4 && mem_cyc_o |->
    mem_adr_o == pc_q + {27'h0, pf_q, 2'b00})
    else $error("prefetch address wrong");
  a_run_after_four: assert property ($rose(run_o) |-> in_pf_q && pf_q == 3'h4)
    else $error("run began without four prefetches");
  a_halt_entry: assert property (mem_cyc_o && mem_err_i |-> ##[1:4]
    processor_status_code_o == 4'h5)
    else $error("fault did not halt");
  a_halt_quiet: assert property (processor_status_code_o == 4'h5 |-> !run_o && !mem_cyc_o)
    else $error("halted sequencer still active");
  a_pst_values: assert property (processor_status_code_o inside {4'h0, 4'h5})
    else $error("status code out of range");
  a_reset_output_pin_width: assert property ($rose(reset_output_pin_n_o) |-> lo_q == RESET_OUTPUT_PIN_CYCLES)
    else $error("reset output pulse width wrong");
  a_super_space: assert property (mem_cyc_o |-> mem_super_o)
    else $error("memory request outside supervisor space");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register bus answer wrong");
endmodule : exc_checker

bind reset_exception_priority_unit exc_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .reset_input_pin_n_i(reset_input_pin_n_i),
  .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i), .mem_dat_i(mem_dat_i),
  .mem_adr_o(mem_adr_o), .mem_cyc_o(mem_cyc_o), .mem_iack_o(mem_iack_o),
  .mem_super_o(mem_super_o),
  .processor_status_code_o(processor_status_code_o), .run_o(run_o),
  .reset_output_pin_n_o(reset_output_pin_n_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// File: bench/mem_model.sv
// Memory on the far side: answers acknowledge and vector reads, can fault one access.
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        cyc_i,
  input  wire logic [31:0] adr_i,
  input  wire logic        iack_i,
  input  wire logic [31:0] sp_i,
  input  wire logic [31:0] pc_i,
  input  wire logic [1:0]  dly_i,
  input  wire logic [3:0]  err_at_i,
  output logic             ack_o = 1'b0,
  output logic             err_o = 1'b0,
  output logic [31:0]      dat_o = 32'h0
);
  logic [1:0] wait_q = 2'h0;
  logic [3:0] num_q  = 4'h0;
  logic [3:0] num;

  // Access number, restarted by each acknowledge cycle.
  assign num = iack_i ? 4'h1 : num_q + 4'h1;

  // Answer after dly_i idle cycles; the data line toggles whenever it is not valid.
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    dat_o <= ~dat_o;
    if (!cyc_i) begin
      wait_q <= 2'h0;
    end else if (!ack_o && !err_o) begin
      if (wait_q != dly_i) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q <= 2'h0;
        num_q  <= num;
        if (num == err_at_i) begin
          err_o <= 1'b1;
        end else begin
          ack_o <= 1'b1;
          dat_o <= iack_i ? 32'h0 : adr_i == 32'h0 ? sp_i : adr_i == 32'h4 ? pc_i : ~adr_i;
        end
      end
    end
  end
endmodule : mem_model

// File: bench/tb_top.sv
// Self-checking bench for the reset sequencer and exception arbiter.
`timescale 1ns/1ps
module tb_top;
  import exc_pkg::*;

  logic                clk_i  = 1'b0;
  logic                rst_i  = 1'b1;
  logic                pin_n  = 1'b1;
  logic [EX_COUNT-1:0] pend   = '0;
  logic                ack, err, cyc, iack, reset_output_pin_n, run, wb_ack;
  logic [31:0]         dat, adr, wb_rd;
  logic [3:0]          pst;
  logic [31:0]         wb_adr = 32'h0;
  logic [31:0]         wb_dat = 32'h0;
  logic                wb_we  = 1'b0;
  logic                wb_cyc = 1'b0;
  logic                wb_stb = 1'b0;
  logic [31:0]         sp     = 32'h0;
  logic [31:0]         pc     = 32'h1000;
  logic [1:0]          dly    = 2'h0;
  logic [3:0]          err_at = 4'h0;
  logic [32:0]         log_q[$];
  logic [9:0]          hand_vecs[4] = '{10'h0a2, 10'h082, 10'h204, 10'h003};
  int                  failures = 0;
  int                  comparisons = 0;

  initial forever #2.5 clk_i = ~clk_i;

  reset_exception_priority_unit DUT (.clk_i(clk_i), .rst_i(rst_i),
    .reset_input_pin_n_i(pin_n), .exc_pending_i(pend), .mem_ack_i(ack), .mem_err_i(err),
    .mem_dat_i(dat), .mem_adr_o(adr), .mem_cyc_o(cyc), .mem_iack_o(iack), .mem_tm_o(),
    .mem_super_o(), .processor_status_code_o(pst), .reset_output_pin_n_o(reset_output_pin_n),
    .run_o(run), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(4'hf),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack));

  mem_model mem (.clk_i(clk_i), .cyc_i(cyc), .adr_i(adr), .iack_i(iack), .sp_i(sp),
    .pc_i(pc), .dly_i(dly), .err_at_i(err_at), .ack_o(ack), .err_o(err), .dat_o(dat));

  // Log every acknowledged access; acknowledge cycles carry no meaningful address.
  always @(posedge clk_i) begin
    if (cyc === 1'b1 && ack === 1'b1) log_q.push_back({iack, iack ? 32'h0 : adr});
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb_io(input logic [31:0] a, input logic we, input logic [31:0] d,
                       output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
  endtask : wb_io

  function automatic logic cond(int sel);
    case (sel)
      0: return run === 1'b1;
      1: return pst === 4'h5;
      2: return reset_output_pin_n === 1'b0;
      default: return log_q.size() >= 5;
    endcase
  endfunction : cond

  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (!cond(sel) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      report_and_stop();
    end
  endtask : wait_for

  // Pin low long enough to pass the synchroniser; the log restarts meanwhile.
  task automatic pulse_pin();
    pin_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    log_q.delete();
    pin_n <= 1'b1;
  endtask : pulse_pin

  task automatic new_vec();
    sp  <= $urandom() & 32'hffff_fffc;
    pc  <= 32'h1000 | ($urandom() & 32'h0fff_fff0);
    dly <= 2'($urandom());
  endtask : new_vec

  function automatic logic [32:0] exp_acc(int i);
    if (i == 0) return {1'b1, 32'h0};
    if (i < 3) return {1'b0, 32'(4 * (i - 1))};
    return {1'b0, pc + 32'(4 * (i - 3))};
  endfunction : exp_acc

  // Winner is the lowest pending index; indices 3 and 4 share a group.
  function automatic logic [32:0] arb(logic [9:0] p);
    int w;
    logic [3:0] g;
    w = 10;
    for (int i = 9; i >= 0; i--) if (p[i]) w = i;
    g = (w <= 3) ? 4'(w) : 4'(w - 1);
    return {24'h0, g, |p, p[9] && w != 9 && w != 0, p[7] && (w == 3 || w == 4 || w == 5),
            w == 1 && p[7] && !p[5], w == 1 && p[5]};
  endfunction : arb

  task automatic boot_check();
    logic [31:0] r;
    wait_for(0);
    check(33'(log_q.size()), 33'd7);
    for (int i = 0; i < 7; i++) check(log_q[i], exp_acc(i));
    wb_io(WB_ADR_SR, 1'b0, 32'h0, r);
    check({17'h0, r[15:0] & 16'hf700}, 33'h2700);
    wb_io(WB_ADR_VBR, 1'b0, 32'h0, r);
    check({1'b0, r}, 33'h0);
    wb_io(WB_ADR_CACHE_CONTROL_REGISTER, 1'b0, 32'h0, r);
    check({1'b0, r & 32'h8000_8000}, 33'h0);
    for (int i = 0; i < 5; i++) begin
      wb_io(WB_ADR_TC + 32'(4 * i), 1'b0, 32'h0, r);
      check({32'h0, r[15]}, 33'h0);
    end
    wb_io(WB_ADR_ISP, 1'b0, 32'h0, r);
    check({1'b0, r}, {1'b0, sp});
    wb_io(WB_ADR_PC, 1'b0, 32'h0, r);
    check({1'b0, r}, {1'b0, pc});
  endtask : boot_check

  ////////////////////////////////////////////////////////////////////////////////
  // Boots, a restart in mid-prefetch, faults, the reset instruction, then arbitration.
  initial begin
    logic [31:0] r, sr0;
    logic [9:0] v;
    int n;
    void'($urandom(32'h4d79));
    new_vec();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    boot_check();
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) wb_io(WB_ADR_SR + 32'(4 * i), 1'b1, 32'hffff_ffff, r);
      new_vec();
      pulse_pin();
      if (k == 2) begin
        wait_for(3);
        pulse_pin();
      end
      boot_check();
      wb_io(WB_ADR_TC, 1'b0, 32'h0, r);
      check({1'b0, r}, 33'h0_ffff_7fff);
    end
    for (int j = 0; j < 4; j++) begin
      err_at <= 4'(2 * j + 1);
      pulse_pin();
      wait_for(1);
      check({32'h0, run}, 33'h0);
    end
    err_at <= 4'h0;
    pulse_pin();
    boot_check();
    wb_io(WB_ADR_SR, 1'b0, 32'h0, sr0);
    wb_io(WB_ADR_CMD, 1'b1, 32'h1, r);
    wait_for(2);
    n = 0;
    while (reset_output_pin_n === 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check(33'(n), 33'(RESET_OUTPUT_PIN_CYCLES));
    wb_io(WB_ADR_SR, 1'b0, 32'h0, r);
    check({1'b0, r}, {1'b0, sr0});
    check({32'h0, run}, 33'h1);
    check(33'(log_q.size()), 33'd7);
    for (int i = 0; i < 24; i++) begin
      v = 10'($urandom() & 32'h3f8);
      if (i < 4) v = hand_vecs[i];
      else if (v == 10'h0) v = 10'h200;
      pend <= v;
      repeat (2) @(posedge clk_i);
      wb_io(WB_ADR_RESULT, 1'b0, 32'h0, r);
      check({1'b0, r}, arb(v));
    end
    report_and_stop();
  end
endmodule : tb_top
